// [rtl/clock_gen_regs.vh]
// register map, field layout and default settings of the system clock generator
`ifndef CLOCK_GEN_REGS_VH
`define CLOCK_GEN_REGS_VH

`define ADDR_SYSCLK_ONE_PLL_DIVIDERS    8'hab
`define ADDR_SYSCLK_ONE_REFERENCE_SETUP 8'hac
`define ADDR_SYSCLK_TWO_PLL_DIVIDERS    8'had
`define ADDR_SYSCLK_TWO_REFERENCE_SETUP 8'hae

`define PLL_MAIN_DIV_MSB  11
`define PLL_VCO_DIV_LSB   12
`define PLL_VCO_DIV_MSB   15
`define REF_DIV_MSB       12
`define REF_SRC_BIT       14
`define REF_ENABLE_BIT    15

`define CLOCK_PARAM_COUNT 5
`define PARAM_IDX_SOURCE  3'h0
`define PARAM_IDX_ADC     3'h1
`define PARAM_IDX_TIMER   3'h2
`define PARAM_IDX_DSP     3'h3
`define PARAM_IDX_MAIN    3'h4

`define DEF_SOURCE_SEL    16'h0000
`define DEF_ADC_DIV       16'h0014
`define DEF_TIMER_DIV     16'h12c0
`define DEF_DSP_DIV       16'h0002
`define DEF_MAIN_INC_HI   16'h192a

`endif

// [rtl/digital_system_clock_generator.v]
// main clock, divided internal clocks and two programmable system clock outputs
`timescale 1ns/1ps
`include "clock_gen_regs.vh"

module digital_system_clock_generator (
    // clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // crystal rate enable
    input  wire        xtal_tick,
    // host register writes
    input  wire        wr_en,
    input  wire [7:0]  wr_addr,
    input  wire [15:0] wr_data,
    // clock parameter block load
    input  wire        param_load,
    input  wire [2:0]  param_index,
    input  wire [15:0] param_data,
    // operating mode
    input  wire        idle_mode,
    // internal clock enables
    output reg         main_tick,
    output wire        adc_tick,
    output wire        general_purpose_timer,
    output wire        dsp_tick,
    output reg         host_poll_enable,
    // system clock outputs
    output wire        aux_clock_out_one,
    output wire        aux_clock_out_two
);

    // three divided internal clocks and two system clock channels
    localparam DIV_COUNT  = 3;
    localparam CHAN_COUNT = 2;

    reg  [15:0]           clock_param [0:`CLOCK_PARAM_COUNT-1];
    reg  [23:0]           main_acc;
    wire [24:0]           main_sum;
    wire [DIV_COUNT-1:0]  div_ticks;
    wire [CHAN_COUNT-1:0] sys_out;

    // defaults are those for a 19.2MHz oscillator
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_param[`PARAM_IDX_SOURCE] <= `DEF_SOURCE_SEL;
            clock_param[`PARAM_IDX_ADC]    <= `DEF_ADC_DIV;
            clock_param[`PARAM_IDX_TIMER]  <= `DEF_TIMER_DIV;
            clock_param[`PARAM_IDX_DSP]    <= `DEF_DSP_DIV;
            clock_param[`PARAM_IDX_MAIN]   <= `DEF_MAIN_INC_HI;
        // indices beyond the last parameter are ignored
        end else if (param_load && param_index < `CLOCK_PARAM_COUNT) begin
            clock_param[param_index] <= param_data;
        end
    end

    // phase accumulator locked to core_clk gives the main clock rate:
    // rate = core rate x increment / 2^16, the carry out is the tick
    assign main_sum = {1'b0, main_acc} + {1'b0, clock_param[`PARAM_IDX_MAIN], 8'h00};

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_acc  <= 24'h000000;
            main_tick <= 1'b0;
        end else begin
            main_acc  <= main_sum[23:0];
            main_tick <= main_sum[24];
        end
    end

    // converter, timer and dsp dividers, source chosen per divider
    genvar d;
    generate
        for (d = 0; d < DIV_COUNT; d = d + 1) begin : g_div
            reg  [15:0] cnt;
            reg         tick;
            // a limit of zero or one divides by one
            wire [15:0] limit = clock_param[`PARAM_IDX_ADC + d];
            wire        src   = clock_param[`PARAM_IDX_SOURCE][d] ? main_tick : xtal_tick;
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt  <= 16'h0000;
                    tick <= 1'b0;
                end else begin
                    tick <= 1'b0;
                    if (src) begin
                        if (cnt + 16'h0001 >= limit) begin
                            cnt  <= 16'h0000;
                            tick <= 1'b1;
                        end else begin
                            cnt <= cnt + 16'h0001;
                        end
                    end
                end
            end
            assign div_ticks[d] = tick;
        end
    endgenerate

    // every divided clock enable leaves straight from its divider flip-flop
    assign adc_tick              = div_ticks[0];
    assign general_purpose_timer = div_ticks[1];
    assign dsp_tick              = div_ticks[2];

    // in idle the host interface is only serviced on timer ticks
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_poll_enable <= 1'b0;
        end else if (idle_mode) begin
            host_poll_enable <= div_ticks[1];
        end else begin
            host_poll_enable <= 1'b1;
        end
    end

    // two identical system clock channels
    genvar c;
    generate
        for (c = 0; c < CHAN_COUNT; c = c + 1) begin : g_sys
            localparam [7:0] PLL_ADDR = (c == 0) ? `ADDR_SYSCLK_ONE_PLL_DIVIDERS
                                                 : `ADDR_SYSCLK_TWO_PLL_DIVIDERS;
            localparam [7:0] REF_ADDR = (c == 0) ? `ADDR_SYSCLK_ONE_REFERENCE_SETUP
                                                 : `ADDR_SYSCLK_TWO_REFERENCE_SETUP;
            reg  [15:0] pll_reg;
            reg  [15:0] ref_reg;
            reg  [12:0] ref_cnt;
            reg         ref_tick;
            reg  [15:0] per_cnt;
            reg  [15:0] period;
            reg  [31:0] acc;
            reg         clk_out;
            // clearing the enable bit powersaves this channel alone
            wire        enable  = ref_reg[`REF_ENABLE_BIT];
            // reference taken from the crystal or the main clock
            wire        ref_src = ref_reg[`REF_SRC_BIT] ? main_tick : xtal_tick;
            wire [4:0]  vco_div = {1'b0, pll_reg[`PLL_VCO_DIV_MSB:`PLL_VCO_DIV_LSB]} + 5'h01;
            wire [20:0] span;
            wire [31:0] thresh;
            wire [31:0] step    = {19'h00000, pll_reg[`PLL_MAIN_DIV_MSB:0], 1'b0};
            wire [31:0] acc_sum = acc + step;
            wire        pll_hit = wr_en && (wr_addr == PLL_ADDR);
            wire        ref_hit = wr_en && (wr_addr == REF_ADDR);

            // period x V needs up to 20 bits, a 16-bit product would wrap
            assign span   = {5'h00, period} * {16'h0000, vco_div};
            assign thresh = {11'h000, span};

            // registers are write-only; other addresses match neither hit
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pll_reg <= 16'h0000;
                    ref_reg <= 16'h0000;
                end else begin
                    if (pll_hit)
                        pll_reg <= wr_data;
                    if (ref_hit)
                        ref_reg <= wr_data;
                end
            end

            // reference divider
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ref_cnt  <= 13'h0000;
                    ref_tick <= 1'b0;
                end else begin
                    ref_tick <= 1'b0;
                    // a powersaved channel restarts its reference count
                    if (!enable) begin
                        ref_cnt <= 13'h0000;
                    end else if (ref_src) begin
                        if (ref_cnt + 13'h0001 >= ref_reg[`REF_DIV_MSB:0]) begin
                            ref_cnt  <= 13'h0000;
                            ref_tick <= 1'b1;
                        end else begin
                            ref_cnt <= ref_cnt + 13'h0001;
                        end
                    end
                end
            end

            // measure divided reference period in core cycles, saturating
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    per_cnt <= 16'h0000;
                    period  <= 16'h0000;
                end else if (!enable) begin
                    per_cnt <= 16'h0000;
                    period  <= 16'h0000;
                end else if (ref_tick) begin
                    per_cnt <= 16'h0000;
                    // a reference slower than the counter span keeps the longest period
                    if (per_cnt == 16'hffff)
                        period <= 16'hffff;
                    else
                        period <= per_cnt + 16'h0001;
                end else if (per_cnt != 16'hffff) begin
                    per_cnt <= per_cnt + 16'h0001;
                end
            end

            // output toggles at 2N per (period x V) cycles: f = fref/R x N / V
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    acc     <= 32'h00000000;
                    clk_out <= 1'b0;
                end else if (!enable || thresh == 32'h00000000) begin
                    acc     <= 32'h00000000;
                    clk_out <= 1'b0;
                // a nonzero threshold at or below the step toggles every cycle
                end else if (acc_sum >= thresh) begin
                    acc     <= acc_sum - thresh;
                    clk_out <= ~clk_out;
                end else begin
                    acc <= acc_sum;
                end
            end
            assign sys_out[c] = clk_out;
        end
    endgenerate

    // system clock levels leave straight from their toggle flip-flops
    assign aux_clock_out_one = sys_out[0];
    assign aux_clock_out_two = sys_out[1];

endmodule // digital_system_clock_generator

// [verif/clock_gen_properties.sv]
// port assertions for the system clock generator
`timescale 1ns/1ps
module clock_gen_props (
    // watched ports
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        xtal_tick,
    input wire logic        wr_en,
    input wire logic [7:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic        idle_mode,
    input wire logic        main_tick,
    input wire logic        adc_tick,
    input wire logic        general_purpose_timer,
    input wire logic        dsp_tick,
    input wire logic        host_poll_enable,
    input wire logic        aux_clock_out_one,
    input wire logic        aux_clock_out_two
);
    logic en_one;
    logic en_two;
    // enable bits as last written by the host
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_one <= 1'b0;
            en_two <= 1'b0;
        end else if (wr_en) begin
            if (wr_addr == 8'hac) en_one <= wr_data[15];
            if (wr_addr == 8'hae) en_two <= wr_data[15];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_one_held_off: assert property (!en_one |=> !aux_clock_out_one) else $error("clock one ran while off");
    a_two_held_off: assert property (!en_two |=> !aux_clock_out_two) else $error("clock two ran while off");
    a_main_tick_spacing: assert property (main_tick |=> !main_tick [*8] ##[1:3] main_tick) else $error("main rate off");
    a_adc_from_xtal: assert property (adc_tick |-> $past(xtal_tick)) else $error("adc tick off source");
    a_timer_from_xtal: assert property (general_purpose_timer |-> $past(xtal_tick)) else $error("timer off source");
    a_dsp_single_tick: assert property (dsp_tick |-> $past(xtal_tick) && !$past(dsp_tick)) else $error("dsp tick bad");
    a_poll_when_busy: assert property (!idle_mode |=> host_poll_enable) else $error("poll low while busy");
    a_poll_follows_timer: assert property ($past(idle_mode) |-> host_poll_enable == $past(general_purpose_timer))
        else $error("idle poll not timer");
endmodule // clock_gen_props
bind digital_system_clock_generator clock_gen_props clock_gen_props_i (.*);

// [verif/host_model.sv]
// host and crystal model for the system clock generator
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire        core_clk,
    // crystal and host lines
    output reg         xtal_tick,
    output reg         wr_en,
    output reg  [7:0]  wr_addr,
    output reg  [15:0] wr_data,
    output reg         param_load,
    output reg  [2:0]  param_index,
    output reg  [15:0] param_data
);
    integer ph = 0;
    initial {xtal_tick, wr_en, wr_addr, wr_data, param_load, param_index, param_data} = 0;
    // crystal near 19.2MHz: one tick per 13 core cycles
    always @(posedge core_clk) begin
        #1;
        ph = (ph + 1) % 13;
        xtal_tick = (ph == 0);
    end
    // one whole word per write, mapped addresses only, lines scrambled once released
    task write_reg(input [7:0] a, input [15:0] d);
        @(posedge core_clk) #1;
        {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(posedge core_clk) #1;
        {wr_en, wr_addr, wr_data} = {1'b0, ~a, ~d};
    endtask
    task load_param(input [2:0] i, input [15:0] d);
        @(posedge core_clk) #1;
        {param_load, param_index, param_data} = {1'b1, i, d};
        @(posedge core_clk) #1;
        {param_load, param_index, param_data} = {1'b0, ~i, ~d};
    endtask
endmodule // host_model

// [verif/digital_system_clock_generator_test.sv]
// self-checking bench for the system clock generator
`timescale 1ns/1ps
module digital_system_clock_generator_test;
    logic core_clk = 0, sys_rst = 1, idle_mode = 0, o1, o2;
    wire xtal_tick, wr_en, param_load, main_tick, adc_tick, gpt, dsp_tick, poll, aux_one, aux_two;
    wire [7:0] wr_addr;
    wire [15:0] wr_data, param_data;
    wire [2:0] param_index;
    integer fails = 0, n_tests = 0, cnt [7];
    wire [6:0] ev = {dsp_tick, adc_tick, gpt, poll, main_tick, aux_two ^ o2, aux_one ^ o1};
    host_model host_model_i (.core_clk(core_clk), .xtal_tick(xtal_tick), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .param_load(param_load), .param_index(param_index), .param_data(param_data));
    digital_system_clock_generator digital_system_clock_generator_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .xtal_tick(xtal_tick), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .param_load(param_load),
        .param_index(param_index), .param_data(param_data), .idle_mode(idle_mode), .main_tick(main_tick),
        .adc_tick(adc_tick), .general_purpose_timer(gpt), .dsp_tick(dsp_tick), .host_poll_enable(poll),
        .aux_clock_out_one(aux_one), .aux_clock_out_two(aux_two));
    initial forever #2 core_clk = ~core_clk;
    // event counts: toggles one/two, main, poll, timer, adc, dsp
    always @(posedge core_clk) begin
        o1 <= aux_one;
        o2 <= aux_two;
        for (int i = 0; i < 7; i++) cnt[i] <= cnt[i] + ev[i];
    end
    task window(input integer n);
        @(posedge core_clk) #1;
        for (int i = 0; i < 7; i++) cnt[i] = 0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    function string ev_name(input integer i);
        case (i)
            0: return "toggles one";
            1: return "toggles two";
            2: return "main ticks";
            3: return "poll cycles";
            4: return "timer ticks";
            5: return "adc ticks";
            default: return "dsp ticks";
        endcase
    endfunction
    task check_all(input integer e0, input integer e1, input integer e2, input integer e3,
                   input integer e4, input integer e5, input integer e6);
        integer e [7];
        e[0] = e0;
        e[1] = e1;
        e[2] = e2;
        e[3] = e3;
        e[4] = e4;
        e[5] = e5;
        e[6] = e6;
        for (int i = 0; i < 7; i++) begin
            n_tests++;
            if ((cnt[i] >= e[i] - (e[i] > 0) && cnt[i] <= e[i] + (e[i] > 0)) !== 1'b1) begin
                fails++;
                $display("unexpected %s: expected %0d, seen %0d", ev_name(i), e[i], cnt[i]);
            end
        end
        $display("test done, %0d mismatches so far", fails);
    endtask
    task give_verdict;
        $display("%0d checks, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #160000;
        fails++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 0;
        window(300);
        window(780);
        check_all(0, 0, 77, 780, 0, 3, 30);
        host_model_i.load_param(3'h0, 16'h0000);
        host_model_i.load_param(3'h1, 16'h000a);
        host_model_i.load_param(3'h2, 16'h0006);
        host_model_i.load_param(3'h3, 16'h0003);
        host_model_i.load_param(3'h4, 16'h192a);
        host_model_i.load_param(3'h5, 16'h0001);
        window(300);
        window(780);
        check_all(0, 0, 77, 780, 10, 6, 20);
        // reference divided to 96kHz on both channels
        host_model_i.write_reg(8'hab, 16'h1145);
        host_model_i.write_reg(8'hac, 16'h80c8);
        host_model_i.write_reg(8'had, 16'h028a);
        host_model_i.write_reg(8'hae, 16'h80c8);
        host_model_i.write_reg(8'hab, 16'h1145);
        window(5400);
        window(5200);
        check_all(650, 2600, 511, 5200, 67, 40, 133);
        host_model_i.write_reg(8'hac, 16'h00c8);
        window(100);
        window(2600);
        check_all(0, 1300, 256, 2600, 33, 20, 67);
        idle_mode = 1;
        window(780);
        check_all(0, 390, 77, 10, 10, 6, 20);
        give_verdict;
    end
endmodule // digital_system_clock_generator_test
